//--- core/fbs_core.sv
// Flash block service sequencer: boot check, block read, write, erase and
// protect, entered by a supervisory call written over APB.
// Assumes APB master on clk; inputs synchronous; flash and SRAM held in flops.
//
// Contract
// - Accumulator 00h on call runs boot; parameter block is ignored.
// - Reset clears accumulator to 00h so boot runs after every reset.
// - Wrong first or second key halts any call but boot; boot runs whatever the keys.
// - Boot checks calibration data against 16-bit checksum before releasing.
// - Block read copies 64 flash bytes into SRAM one by one.
// - Read-protected block: accumulator and second key 00h, first key 01h.
// - Read stores first byte at pointer address, rest at following addresses.
// - Successful read leaves accumulator and both keys at 00h.
// - Block write programs 64 SRAM bytes from pointer into numbered block.
// - Write-protected block: no programming, keys 01h/00h, accumulator 00h.
// - Erase sets 64 bytes to FFh after write protection check; same fail codes.
// - Two-bit protection fields packed four per byte, low block low bits.
// - Protection byte k covers blocks 4k to 4k+3.
// - Levels: 00 none, 01 read, 10 external write, 11 internal write.
// - Indexed flash reads are always allowed whatever the protection.
// - Protection only lowered by full erase; here only reset lowers it, clearing it to 00h.
// - Protect ORs SRAM bytes from 80h into protection block.
// - Block erase leaves protection level unchanged.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module fbs_core #(
  parameter int FLASH_BLOCKS = 128
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic [fbs_pkg::AW-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       cpu_run,
  output logic                       cpu_halted
);
  import fbs_pkg::*;

  localparam int FLASH_BYTES = FLASH_BLOCKS * BLK_BYTES;
  localparam int FAW         = $clog2(FLASH_BYTES);

  // ==========================================================
  // Storage
  logic [7:0]     sram_mem  [256];
  logic [7:0]     flash_mem [FLASH_BYTES];
  logic [7:0]     prot_mem  [PROT_BYTES];

  fbs_state_e     state_reg;
  logic [6:0]     idx_reg;
  logic [15:0]    sum_reg;
  logic [16:0]    wait_reg;
  logic [7:0]     acc_reg;
  logic [7:0]     sp_reg;
  logic [FAW-1:0] fidx_reg;
  logic [5:0]     pidx_reg;
  logic           call_reg;
  logic           cal_ok_reg;
  logic           err_reg;

  // ==========================================================
  // Parameter block decode
  logic [7:0]     first_key_slot;
  logic [7:0]     second_key_slot;
  logic [7:0]     blk;
  logic [7:0]     ptr;
  logic [7:0]     sram_at;
  logic [1:0]     lvl;
  logic [FAW-1:0] faddr;
  logic           keys_ok;
  logic           blk_ok;
  logic           last;
  logic [15:0]    sum_next;
  fbs_result_s    res;

  function automatic logic [1:0] lvl_of(input logic [7:0] pb,
                                        input logic [1:0] sel);
    return pb[{sel, 1'b0} +: 2];
  endfunction

  assign first_key_slot     = sram_mem[P_FIRST_KEY_SLOT];
  assign second_key_slot     = sram_mem[P_SECOND_KEY_SLOT];
  assign blk      = sram_mem[P_BLK];
  assign ptr      = sram_mem[P_PTR];
  assign sram_at  = ptr + {2'h0, idx_reg[5:0]};
  assign lvl      = lvl_of(prot_mem[blk[7:2]], blk[1:0]);
  assign faddr    = FAW'({blk, idx_reg[5:0]});
  assign keys_ok  = (first_key_slot == FIRST_KEY_SLOT_VAL) &&
                    (second_key_slot == sp_reg + SECOND_KEY_SLOT_OFS);
  assign blk_ok   = int'(blk) < FLASH_BLOCKS;
  assign last     = idx_reg[5:0] == 6'(BLK_BYTES - 1);
  assign sum_next = sum_reg + {8'h00, CAL_DATA[idx_reg[2:0]]};
  assign res.acc  = ACC_RST;
  assign res.second_key_slot = RC_OK;
  assign res.first_key_slot = (state_reg == S_FAIL) ? RC_PROT : RC_OK;

  // ==========================================================
  // APB slave: pready rises one cycle into the access phase
  logic        apb_acc;
  logic        apb_wr;
  logic        idle;
  logic        sram_hit;
  logic        reg_hit;
  logic        wr_ok;
  logic [31:0] rd_val;

  assign apb_acc  = psel && penable && !pready;
  assign apb_wr   = psel && penable && pready && pwrite && !err_reg;
  assign idle     = state_reg == S_IDLE;
  assign sram_hit = paddr[11:10] == SRAM_WIN && paddr[1:0] == 2'h0;
  assign reg_hit  = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0;
  // Software writes that touch call state are refused while busy or halted
  assign wr_ok    = sram_hit ? idle :
                    (paddr == OFS_ACC || paddr == OFS_CALL) ?
                    (idle && !call_reg) : reg_hit;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (sram_hit) begin
      rd_val[7:0] = sram_mem[paddr[9:2]];
    end else begin
      case (paddr)
        OFS_ACC:   rd_val[7:0] = acc_reg;
        OFS_SP:    rd_val[7:0] = sp_reg;
        OFS_CALL:  rd_val[0]   = call_reg;
        OFS_STAT: begin
          rd_val[ST_RUN]  = cpu_run;
          rd_val[ST_HALT] = cpu_halted;
          rd_val[ST_BUSY] = !idle;
          rd_val[ST_CAL]  = cal_ok_reg;
        end
        OFS_FIDX:  rd_val[FAW-1:0] = fidx_reg;
        OFS_FDATA: rd_val[7:0] = flash_mem[fidx_reg];
        OFS_PIDX:  rd_val[5:0] = pidx_reg;
        OFS_PDATA: rd_val[7:0] = prot_mem[pidx_reg];
        default:   rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      err_reg <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready <= apb_acc;
      if (apb_acc) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= pwrite ? !wr_ok : !(sram_hit || reg_hit);
        err_reg <= pwrite ? !wr_ok : 1'b0;
      end else begin
        pslverr <= 1'b0;
        err_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sp_reg   <= 8'h00;
      fidx_reg <= '0;
      pidx_reg <= 6'h00;
    end else if (ce && apb_wr) begin
      if (paddr == OFS_SP) begin
        sp_reg <= pwdata[7:0];
      end
      if (paddr == OFS_FIDX) begin
        fidx_reg <= pwdata[FAW-1:0];
      end
      if (paddr == OFS_PIDX) begin
        pidx_reg <= pwdata[5:0];
      end
    end
  end

  // Accumulator: cleared by reset so boot follows every reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= ACC_RST;
    end else if (ce) begin
      if (state_reg == S_DONE || state_reg == S_FAIL) begin
        acc_reg <= res.acc;
      end else if (apb_wr && paddr == OFS_ACC) begin
        acc_reg <= pwdata[7:0];
      end
    end
  end

  // Call request: taken by the sequencer only from idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      call_reg <= 1'b0;
    end else if (ce) begin
      if (apb_wr && paddr == OFS_CALL && pwdata[CALL_GO]) begin
        call_reg <= 1'b1;
      end else if (idle) begin
        call_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= S_BOOT;
      idx_reg    <= 7'h00;
      sum_reg    <= 16'h0000;
      wait_reg   <= 17'h00000;
      cpu_run    <= 1'b0;
      cpu_halted <= 1'b0;
      cal_ok_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        S_BOOT: begin
          sum_reg <= sum_next;
          idx_reg <= idx_reg + 7'h01;
          if (idx_reg[2:0] == 3'(CAL_N - 1)) begin
            // User code only starts on a matching checksum
            cal_ok_reg <= sum_next == CAL_SUM;
            cpu_run    <= sum_next == CAL_SUM;
            cpu_halted <= sum_next != CAL_SUM;
            state_reg  <= (sum_next == CAL_SUM) ? S_IDLE : S_HALT;
          end
        end
        S_IDLE: begin
          idx_reg <= 7'h00;
          sum_reg <= 16'h0000;
          if (call_reg) begin
            if (acc_reg == FN_BOOT) begin
              cpu_run   <= 1'b0;
              state_reg <= S_BOOT;
            end else begin
              state_reg <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          wait_reg <= 17'((17'(sram_mem[P_DLY]) + 17'h00001) *
                          (17'(sram_mem[P_CLK]) + 17'h00001));
          // Nothing in flash changes until keys and level pass
          if (!keys_ok) begin
            state_reg <= S_HALT;
          end else begin
            case (acc_reg)
              FN_READ:
                state_reg <= !blk_ok ? S_HALT :
                             lvl[0] ? S_FAIL : S_READ;
              FN_WRITE:
                state_reg <= !blk_ok ? S_HALT :
                             (lvl == LVL_IW) ? S_FAIL : S_WRITE;
              FN_ERASE:
                state_reg <= !blk_ok ? S_HALT :
                             (lvl == LVL_IW) ? S_FAIL : S_ERASE;
              FN_PROT:  state_reg <= S_PROT;
              default:  state_reg <= S_HALT;
            endcase
          end
        end
        S_READ, S_WRITE, S_ERASE, S_PROT: begin
          idx_reg <= idx_reg + 7'h01;
          if (last) begin
            state_reg <= (state_reg == S_READ) ? S_DONE : S_PULSE;
          end
        end
        S_PULSE: begin
          // Models the program or erase pulse set by divider and delay
          if (wait_reg <= 17'h00001) begin
            state_reg <= S_DONE;
          end else begin
            wait_reg <= wait_reg - 17'h00001;
          end
        end
        S_DONE, S_FAIL: begin
          state_reg <= S_IDLE;
        end
        S_HALT: begin
          cpu_run    <= 1'b0;
          cpu_halted <= 1'b1;
        end
        default: state_reg <= S_HALT;
      endcase
    end
  end

  // ==========================================================
  // SRAM: software port when idle, sequencer otherwise
  always_ff @(posedge clk) begin
    if (ce) begin
      if (state_reg == S_READ) begin
        sram_mem[sram_at] <= flash_mem[faddr];
      end else if (state_reg == S_DONE || state_reg == S_FAIL) begin
        sram_mem[P_FIRST_KEY_SLOT] <= res.first_key_slot;
        sram_mem[P_SECOND_KEY_SLOT] <= res.second_key_slot;
      end else if (apb_wr && sram_hit) begin
        sram_mem[paddr[9:2]] <= pwdata[7:0];
      end
    end
  end

  // Flash array: program overwrites, erase fills the erased value
  always_ff @(posedge clk) begin
    if (ce) begin
      if (state_reg == S_WRITE) begin
        flash_mem[faddr] <= sram_mem[sram_at];
      end else if (state_reg == S_ERASE) begin
        flash_mem[faddr] <= ERASE_VAL;
      end
    end
  end

  // Protection block: ORed by protect calls, cleared to 00h only by reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < PROT_BYTES; i++) begin
        prot_mem[i] <= 8'h00;
      end
    end else if (ce && state_reg == S_PROT) begin
      prot_mem[idx_reg[5:0]] <= prot_mem[idx_reg[5:0]] |
                                sram_mem[PROT_SRC + {2'h0, idx_reg[5:0]}];
    end
  end

endmodule

`default_nettype wire

//--- core/fbs_pkg.sv
// Constants, states and result struct for the flash block service sequencer.
// Assumes one clock domain and an APB register port with 32-bit data.
package fbs_pkg;

  // ==========================================================
  // APB register map (byte addresses)
  localparam int          AW        = 12;
  localparam logic [11:0] OFS_ACC   = 12'h000;
  localparam logic [11:0] OFS_SP    = 12'h004;
  localparam logic [11:0] OFS_CALL  = 12'h008;
  localparam logic [11:0] OFS_STAT  = 12'h00C;
  localparam logic [11:0] OFS_FIDX  = 12'h010;
  localparam logic [11:0] OFS_FDATA = 12'h014;
  localparam logic [11:0] OFS_PIDX  = 12'h018;
  localparam logic [11:0] OFS_PDATA = 12'h01C;
  localparam logic [1:0]  SRAM_WIN  = 2'h1;   // paddr[11:10], 0x400..0x7FC
  localparam int          ST_RUN    = 0;
  localparam int          ST_HALT   = 1;
  localparam int          ST_BUSY   = 2;
  localparam int          ST_CAL    = 3;
  localparam int          CALL_GO   = 0;

  // ==========================================================
  // Parameter block slots in SRAM
  localparam logic [7:0] P_FIRST_KEY_SLOT   = 8'hF8;
  localparam logic [7:0] P_SECOND_KEY_SLOT   = 8'hF9;
  localparam logic [7:0] P_BLK    = 8'hFA;
  localparam logic [7:0] P_PTR    = 8'hFB;
  localparam logic [7:0] P_CLK    = 8'hFC;
  localparam logic [7:0] P_DLY    = 8'hFE;
  localparam logic [7:0] PROT_SRC = 8'h80;

  // ==========================================================
  // Keys, function codes, return codes, protection levels
  localparam logic [7:0] FIRST_KEY_SLOT_VAL  = 8'h3A;
  localparam logic [7:0] SECOND_KEY_SLOT_OFS  = 8'h03;
  localparam logic [7:0] FN_BOOT   = 8'h00;
  localparam logic [7:0] FN_READ   = 8'h01;
  localparam logic [7:0] FN_WRITE  = 8'h02;
  localparam logic [7:0] FN_ERASE  = 8'h03;
  localparam logic [7:0] FN_PROT   = 8'h04;
  localparam logic [7:0] RC_OK     = 8'h00;
  localparam logic [7:0] RC_PROT   = 8'h01;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [1:0] LVL_NONE  = 2'h0;
  localparam logic [1:0] LVL_RD    = 2'h1;
  localparam logic [1:0] LVL_XW    = 2'h2;
  localparam logic [1:0] LVL_IW    = 2'h3;
  localparam int         BLK_BYTES = 64;
  localparam int         PROT_BYTES = 64;
  localparam logic [7:0] ERASE_VAL = 8'hFF;

  // ==========================================================
  // Calibration image checked at boot
  localparam int          CAL_N = 8;
  localparam logic [7:0]  CAL_DATA [CAL_N] = '{8'h11, 8'h22, 8'h33, 8'h44,
                                               8'h55, 8'h66, 8'h77, 8'h88};
  localparam logic [15:0] CAL_SUM = 16'h0264;

  typedef enum logic [3:0] {
    S_BOOT, S_IDLE, S_CHECK, S_READ, S_WRITE, S_ERASE, S_PROT,
    S_PULSE, S_DONE, S_FAIL, S_HALT
  } fbs_state_e;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] first_key_slot;
    logic [7:0] second_key_slot;
  } fbs_result_s;

endpackage

//--- tb/fbs_chk.sv
// Port checker for the flash block service sequencer.
// Assumes ce drops only while the bus is idle; calibration image matches.
`timescale 1ns/1ps
`default_nettype none
module fbs_chk
  import fbs_pkg::*;
#(
  parameter int FLASH_BLOCKS = 128
) (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    ce,
  input wire logic [fbs_pkg::AW-1:0]  paddr,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    cpu_run,
  input wire logic                    cpu_halted
);
  // ======
  // Enabled edges since reset release, saturating
  logic [3:0] boot_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_cnt <= 4'h0;
    end else if (ce && boot_cnt != 4'hF) begin
      boot_cnt <= boot_cnt + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ======
  // Assertions
  ready_delay_a: assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  unmapped_err_a: assert property (pready && (paddr[1:0] != 2'h0 || paddr[11]
    || (!paddr[10] && paddr[9:5] != 5'h0)) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  boot_hold_a: assert property (boot_cnt < 4'h8 |-> !cpu_run)
    else $error("cpu released before checksum");
  boot_release_a: assert property (boot_cnt == 4'h8 |-> cpu_run)
    else $error("boot did not release cpu");
  halt_sticky_a: assert property (cpu_halted |=> cpu_halted && !cpu_run)
    else $error("halt left without reset");
endmodule
`default_nettype wire

//--- tb/fbs_cpu_model.sv
// CPU side model: APB master issuing supervisory calls.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module fbs_cpu_model
  import fbs_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    pready,
  input  wire logic                    pslverr,
  input  wire logic [31:0]             prdata,
  output logic      [fbs_pkg::AW-1:0]  paddr,
  output logic                         psel,
  output logic                         penable,
  output logic                         pwrite,
  output logic      [31:0]             pwdata
);
  int hangs;
  logic [7:0] key_sp;
  logic [7:0] key_first;
  initial begin
    key_sp = 8'h00;
    key_first = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    hangs = 0;
  end
  // ======
  // Bus transfer; idle edge after each so no signal is set twice per step
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hangs++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines carry junk, not the last value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask
  task automatic sram(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, {SRAM_WIN, a, 2'b00}, {24'h0, d}, r, e);
  endtask
  // Keys, minimal pulse timing
  task automatic keys(input logic [7:0] sp, input logic [7:0] k1);
    logic [31:0] r;
    logic e;
    key_sp = sp;
    key_first = k1;
    xfer(1'b1, OFS_SP, {24'h0, sp}, r, e);
    sram(P_CLK, 8'h00);
    sram(P_DLY, 8'h00);
  endtask
  task automatic blk(input logic [7:0] b, input logic [7:0] p);
    sram(P_BLK, b);
    sram(P_PTR, p);
  endtask
  task automatic call(input logic [7:0] fn);
    logic [31:0] r;
    logic e;
    int n;
    // Return codes overwrite the key slots, so every call sets them anew
    sram(P_FIRST_KEY_SLOT, key_first);
    sram(P_SECOND_KEY_SLOT, key_sp + SECOND_KEY_SLOT_OFS);
    xfer(1'b1, OFS_ACC, {24'h0, fn}, r, e);
    xfer(1'b1, OFS_CALL, 32'h1, r, e);
    n = 0;
    // A halted sequencer stays busy, so halt also ends the wait
    do begin
      xfer(1'b0, OFS_STAT, 32'h0, r, e);
      n++;
    end while (r[ST_HALT] !== 1'b1 && (r[ST_BUSY] !== 1'b0 ||
               r[ST_RUN] !== 1'b1) && n < 200);
    if (n >= 200) hangs++;
  endtask
endmodule
`default_nettype wire

//--- tb/flash_block_service_calls_bench.sv
// Self-checking bench for the flash block service sequencer.
// Assumes fbs_core, fbs_chk and fbs_cpu_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module flash_block_service_calls_bench;
  import fbs_pkg::*;
  logic              clk;
  logic              resetn;
  logic              ce;
  logic [AW-1:0]     paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              cpu_run;
  logic              cpu_halted;
  int                failures;
  int                check_count;
  typedef struct {logic [11:0] a; logic [31:0] d; logic e;} fbs_row_s;
  fbs_row_s rows [4] = '{'{OFS_ACC, 32'h0, 1'b0}, '{OFS_STAT, 32'h9, 1'b0},
                         '{12'h020, 32'h0, 1'b1}, '{12'h002, 32'h0, 1'b1}};
  fbs_core #(.FLASH_BLOCKS(128)) uut (.clk(clk), .resetn(resetn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_run(cpu_run), .cpu_halted(cpu_halted));
  fbs_cpu_model cpu (.clk(clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata));
  // ======
  // Helpers
  function automatic logic [7:0] pat(int i);
    return 8'(i * 7 + 1);
  endfunction
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    cpu.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    cpu.xfer(1'b1, a, d, r, e);
  endtask
  task automatic ret(input logic [7:0] k1);
    logic [31:0] r;
    rd({SRAM_WIN, P_FIRST_KEY_SLOT, 2'b00}, r);
    chk("first_key_slot", r, {24'h0, k1});
    rd({SRAM_WIN, P_SECOND_KEY_SLOT, 2'b00}, r);
    chk("second_key_slot", r, 32'h0);
    rd(OFS_ACC, r);
    chk("acc", r, 32'h0);
  endtask
  task automatic conclude;
    failures += cpu.hangs;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ======
  // Clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    logic [31:0] r;
    logic e;
    failures = 0;
    check_count = 0;
    resetn = 1'b0;
    ce = 1'b1;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (12) @(posedge clk);
    foreach (rows[i]) begin
      cpu.xfer(1'b0, rows[i].a, 32'h0, r, e);
      chk("row data", r, rows[i].d);
      chk("row err", {31'h0, e}, {31'h0, rows[i].e});
    end
    // Bad key with boot code still boots
    cpu.keys(8'h40, 8'h00);
    cpu.call(FN_BOOT);
    rd(OFS_STAT, r);
    chk("boot status", r & 32'h3, 32'h1);
    cpu.keys(8'h40, FIRST_KEY_SLOT_VAL);
    for (int i = 0; i < 64; i++) cpu.sram(8'h10 + 8'(i), pat(i));
    cpu.blk(8'h05, 8'h10);
    cpu.call(FN_WRITE);
    ret(RC_OK);
    cpu.blk(8'h05, 8'h40);
    cpu.call(FN_READ);
    ret(RC_OK);
    for (int i = 0; i < 64; i++) begin
      rd({SRAM_WIN, 8'h40 + 8'(i), 2'b00}, r);
      chk("read copy", r, {24'h0, pat(i)});
    end
    // Block 5 to read protect: byte 1, bits 3:2
    for (int i = 0; i < 64; i++) begin
      cpu.sram(PROT_SRC + 8'(i), i == 1 ? 8'h04 : 8'h00);
    end
    cpu.call(FN_PROT);
    ret(RC_OK);
    wr(OFS_PIDX, 32'h1);
    rd(OFS_PDATA, r);
    chk("prot byte", r, 32'h04);
    cpu.call(FN_READ);
    ret(RC_PROT);
    wr(OFS_FIDX, 32'h143);
    rd(OFS_FDATA, r);
    chk("indexed read", r, {24'h0, pat(3)});
    cpu.call(FN_ERASE);
    ret(RC_OK);
    rd(OFS_FDATA, r);
    chk("erased", r, {24'h0, ERASE_VAL});
    rd(OFS_PDATA, r);
    chk("prot kept", r, 32'h04);
    // Erase then all-zero write to destroy the old data
    for (int i = 0; i < 64; i++) cpu.sram(8'h40 + 8'(i), 8'h00);
    cpu.call(FN_WRITE);
    ret(RC_OK);
    rd(OFS_FDATA, r);
    chk("zeroed", r, 32'h0);
    cpu.sram(8'h81, 8'h08);
    cpu.call(FN_PROT);
    rd(OFS_PDATA, r);
    chk("prot or", r, 32'h0C);
    cpu.sram(8'h43, 8'h5A);
    cpu.call(FN_WRITE);
    ret(RC_PROT);
    cpu.call(FN_ERASE);
    ret(RC_PROT);
    rd(OFS_FDATA, r);
    chk("flash kept", r, 32'h0);
    // Bad key, unknown code, block past the end: each halts until reset
    for (int k = 0; k < 3; k++) begin
      cpu.keys(8'h40, k == 0 ? 8'h3B : FIRST_KEY_SLOT_VAL);
      cpu.blk(k == 2 ? 8'h80 : 8'h05, 8'h40);
      cpu.call(k == 1 ? 8'h0F : FN_READ);
      rd(OFS_STAT, r);
      chk("halted", r & 32'h3, 32'h2);
      chk("halt pin", {31'h0, cpu_halted}, 32'h1);
      cpu.xfer(1'b1, OFS_ACC, 32'h1, r, e);
      chk("refused", {31'h0, e}, 32'h1);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      // Clock enable low must freeze the boot sequence
      ce <= 1'b0;
      repeat (12) @(posedge clk);
      ce <= 1'b1;
      rd(OFS_STAT, r);
      chk("boot frozen", r & 32'h3, 32'h0);
      repeat (12) @(posedge clk);
      rd(OFS_STAT, r);
      chk("reboot", r & 32'h3, 32'h1);
      chk("run pin", {31'h0, cpu_run}, 32'h1);
    end
    conclude();
  end
endmodule
bind fbs_core fbs_chk #(.FLASH_BLOCKS(FLASH_BLOCKS)) chk_i (.clk(clk),
  .resetn(resetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_run(cpu_run), .cpu_halted(cpu_halted));
`default_nettype wire
